// ### hw/tach_average.sv
`timescale 1ns/100ps
module tach_average #(
	parameter int DEPTH = 16,
	parameter int LW    = 3
) (
	input  wire logic          clk_sys,
	input  wire logic          sys_rst,
	input  wire logic          restart,
	input  wire logic          moving,
	input  wire logic [LW-1:0] lvl,
	input  tach_pkg::samp_t    in_s,
	output tach_pkg::samp_t    out_s
);
	localparam int AW = $clog2(DEPTH);

	logic [31:0]    ring_r [DEPTH];
	logic [AW-1:0]  wp_r;
	logic [AW:0]    n_r;
	logic [AW+31:0] sum_r;
	logic [AW+31:0] sum_nxt;
	logic [AW:0]    need;
	logic [AW-1:0]  old_idx;

	// Samples per average; when need equals DEPTH the oldest sits at wp_r
	assign need    = (AW+1)'(1) << lvl;
	assign old_idx = wp_r - need[AW-1:0];

	// Running sum: a moving window drops its oldest sample
	always_comb
	begin
		sum_nxt = sum_r + (AW+32)'(in_s.val);
		if (moving)
			sum_nxt = sum_nxt - (AW+32)'(ring_r[old_idx]);
	end

	always_ff @(posedge clk_sys)
	begin
		out_s.vld <= 1'b0;
		if (sys_rst || restart)
		begin
			for (int i = 0; i < DEPTH; i++)
				ring_r[i] <= 32'h00000000;
			wp_r      <= '0;
			n_r       <= '0;
			sum_r     <= '0;
			out_s     <= '0;
		end
		else if (in_s.vld)
		begin
			ring_r[wp_r] <= in_s.val;
			wp_r         <= wp_r + AW'(1);
			if (moving)
			begin
				sum_r     <= sum_nxt;
				out_s.vld <= 1'b1;
				out_s.val <= 32'(sum_nxt >> lvl);
			end
			else if (n_r + (AW+1)'(1) >= need)
			begin
				sum_r     <= '0;
				n_r       <= '0;
				out_s.vld <= 1'b1;
				out_s.val <= 32'(sum_nxt >> lvl);
			end
			else
			begin
				sum_r <= sum_nxt;
				n_r   <= n_r + (AW+1)'(1);
			end
		end
	end
endmodule

// ### hw/tach_params.svh
`ifndef TACH_PARAMS_SVH
`define TACH_PARAMS_SVH

// Register byte offsets
`define ADR_CTRL     8'h00
`define ADR_PRESCALE 8'h04
`define ADR_SV1      8'h08
`define ADR_SV2      8'h0C
`define ADR_HYST     8'h10
`define ADR_AZERO    8'h14
`define ADR_STARTUP  8'h18
`define ADR_OFFDLY   8'h1C
`define ADR_SVLIMIT  8'h20
`define ADR_VALUE    8'h24
`define ADR_PEAK     8'h28
`define ADR_BOTTOM   8'h2C
`define ADR_ONMON1   8'h30
`define ADR_ONMON2   8'h34
`define ADR_STATUS   8'h38

// Reset values and maximum count
`define CTRL_RST     14'h0000
`define PRESCALE_RST 20'h003E8
`define SVLIMIT_RST  32'h000F423F
`define AZERO_RST    16'h03E8
`define STARTUP_RST  16'h0000
`define OFFDLY_RST   16'h0000
`define MAX_COUNT    32'h000F423F

// Timing
`define CLK_NS       10
`define MS_NS        1000000
`define SAMPLE_MS    200
`define CHATTER_MS   2
`define PER_SEC      5
`define KILO         1000

`endif

// ### hw/tach_pkg.sv
package tach_pkg;

	// Comparison modes
	typedef enum logic [2:0] {
		BAND_OUTSIDE_MODE = 3'h0,
		BAND_INSIDE_MODE  = 3'h1,
		OVER_MAX_MODE     = 3'h2,
		UNDER_MIN_MODE    = 3'h3,
		DOUBLE_OVER_MODE  = 3'h4,
		DOUBLE_UNDER_MODE = 3'h5
	} cmp_mode_t;

	// Control word as stored in the control register
	typedef struct packed {
		logic       peak_bottom_capture_enable;
		logic [2:0] decimal_point_place;
		logic [2:0] avg_level;
		logic       moving_average;
		logic [2:0] cmp_mode;
		logic       npn_input;
		logic       slow_speed;
		logic       measure_method_select;
	} cfg_t;

	// One measurement sample with its strobe
	typedef struct packed {
		logic        vld;
		logic [31:0] val;
	} samp_t;

	// Divider sequencer
	typedef enum logic [1:0] {
		DIV_IDLE = 2'b00,
		DIV_RUN  = 2'b01,
		DIV_DONE = 2'b11
	} div_state_t;

endpackage

// ### hw/tachometer_measure_compare.sv
`timescale 1ns/100ps
`include "tach_params.svh"
// Behaviour
// - Method bit picks frequency or period
// - Slow speed adds chatter filter
// - Six comparison modes drive outputs
// - Moving updates each sample, simple per block
// - Average over 1, 2, 4, 8, 16
// - Gate 200 ms at 5 Hz up
// - Below 5 Hz compute per pulse
// - Period mode compares raw, unaveraged
// - One polarity bit for all inputs
// - One decimal place for all values
// - Frequency mode shows frequency times prescale
// - Too-high set value never turns on an over comparison
// - No pulse in auto-zero time gives 0 in frequency mode
// - Startup time inhibits measuring and outputs
// - Track peak and bottom, restart on change
// - Peak kept in external non-volatile store
// - Hysteresis band in scaled units
// - Off delay holds output on
// - Set values clamp at upper limit
// - ON monitor reads count over 1000
// - Hold freezes value, outputs, lights lamp
// - Outputs follow mode on comparison
module tachometer_measure_compare #(
	parameter int MS_CYCLES = `MS_NS / `CLK_NS
) (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        count_in,
	input  wire logic        hold_in,
	input  wire logic [31:0] peak_nv_i,
	output logic      [31:0] peak_nv_o,
	output logic             peak_save,
	output logic             first_control_output,
	output logic             second_control_output,
	output logic             hold_led,
	output logic      [2:0]  decimal_point_place
);
	tach_pkg::cfg_t         cfg_r;
	tach_pkg::div_state_t   dst_r;
	tach_pkg::samp_t        samp;
	tach_pkg::samp_t        avg_s;
	logic [19:0] prescale_r;
	logic [31:0] sv1_r, sv2_r, hyst_r, svlim_r;
	logic [15:0] azero_r, startup_r, offdly_r;
	logic        cnt_s1, cnt_s2, hold_s1, hold_s2;
	logic        cnt_a, hold_a, cnt_f_r, cnt_p_r, edge_p;
	logic [1:0]  chat_r;
	logic [31:0] tick_r;
	logic        tick;
	logic [15:0] up_ms_r;
	logic        starting;
	logic [19:0] since_r, period_r, since_end;
	logic        low_rate, azero_hit;
	logic [7:0]  win_r;
	logic [15:0] pcnt_r;
	logic [31:0] num_r, rem_r, quo_r;
	logic [4:0]  step_r;
	logic [32:0] rem_sh;
	logic [31:0] value_r, raw_r, cmp_v;
	logic        cmp_upd, cfg_wr;
	logic [3:0]  flag_r;
	logic [1:0]  want, drive_r, out_p_r;
	logic [15:0] hold_cnt_r [2];
	logic [9:0]  on_lo_r [2];
	logic [31:0] on_hi_r [2];
	logic [31:0] peak_r, bottom_r;
	logic        wb_req;

	////////////////////////////////////////////////////////////////
	// Helpers

	// Byte-lane merge for register writes
	function automatic logic [31:0] lanes(logic [31:0] old, logic [31:0] nw,
		logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (sel[b])
				r[8*b +: 8] = nw[8*b +: 8];
		return r;
	endfunction

	// Rising-side compare; releases below set value less band
	function automatic logic over_f(logic prev, logic [31:0] v, logic [31:0] sv,
		logic [31:0] h);
		return prev ? ({1'b0, v} + {1'b0, h} >= {1'b0, sv}) : (v >= sv);
	endfunction

	// Falling-side compare; releases above set value plus band
	function automatic logic under_f(logic prev, logic [31:0] v, logic [31:0] sv,
		logic [31:0] h);
		return prev ? ({1'b0, v} <= {1'b0, sv} + {1'b0, h}) : (v <= sv);
	endfunction

	function automatic logic sv_ok(logic [31:0] sv, logic [19:0] ps);
		return sv < (`MAX_COUNT - {12'h000, ps});
	endfunction

	function automatic logic [31:0] clamp(logic [31:0] v, logic [31:0] lim);
		return (v > lim) ? lim : v;
	endfunction

	////////////////////////////////////////////////////////////////
	// Input synchronisers; the first stage feeds only the second
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			cnt_s1  <= 1'b0;
			cnt_s2  <= 1'b0;
			hold_s1 <= 1'b0;
			hold_s2 <= 1'b0;
		end
		else
		begin
			cnt_s1  <= count_in;
			cnt_s2  <= cnt_s1;
			hold_s1 <= hold_in;
			hold_s2 <= hold_s1;
		end
	end

	assign cnt_a  = cnt_s2 ^ cfg_r.npn_input;
	assign hold_a = hold_s2 ^ cfg_r.npn_input;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || tick)
			tick_r <= 32'h00000000;
		else
			tick_r <= tick_r + 32'h00000001;
	end
	assign tick = (tick_r == 32'(MS_CYCLES - 1));

	// chatter filter; contacts must hold a level over two ticks
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			cnt_f_r <= 1'b0;
			chat_r  <= 2'h0;
		end
		else if (!cfg_r.slow_speed || cnt_a == cnt_f_r)
		begin
			cnt_f_r <= cfg_r.slow_speed ? cnt_f_r : cnt_a;
			chat_r  <= 2'h0;
		end
		else if (tick)
		begin
			if (chat_r == 2'(`CHATTER_MS - 1))
				cnt_f_r <= cnt_a;
			chat_r <= chat_r + 2'h1;
		end
	end

	// Pulse edge
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			cnt_p_r <= 1'b0;
		else
			cnt_p_r <= cnt_f_r;
	end
	assign edge_p = cnt_f_r & ~cnt_p_r & ~starting;

	////////////////////////////////////////////////////////////////
	// startup window
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			up_ms_r <= 16'h0000;
		else if (tick && starting)
			up_ms_r <= up_ms_r + 16'h0001;
	end
	assign starting = (up_ms_r < startup_r);

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			since_r  <= 20'h00000;
			period_r <= 20'hFFFFF;
		end
		else if (edge_p)
		begin
			since_r  <= 20'h00000;
			period_r <= since_end;
		end
		else if (tick && since_r != 20'hFFFFF)
			since_r <= since_r + 20'h00001;
	end
	// Ticks up to and including this cycle, so an edge that meets a tick loses none
	assign since_end = (tick && since_r != 20'hFFFFF) ? since_r + 20'h00001 : since_r;
	assign low_rate  = (period_r > 20'(`SAMPLE_MS));
	assign azero_hit = (since_r >= {4'h0, azero_r});

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || starting)
		begin
			win_r  <= 8'h00;
			pcnt_r <= 16'h0000;
		end
		else if (tick && win_r == 8'(`SAMPLE_MS - 1))
		begin
			win_r  <= 8'h00;
			pcnt_r <= 16'(edge_p);
		end
		else
		begin
			if (tick)
				win_r <= win_r + 8'h01;
			if (edge_p)
				pcnt_r <= pcnt_r + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////
	// serial divide: prescale * 1000 / period_ms, 32 steps
	assign rem_sh = {rem_r, num_r[31]};
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			dst_r  <= tach_pkg::DIV_IDLE;
			num_r  <= 32'h00000000;
			rem_r  <= 32'h00000000;
			quo_r  <= 32'h00000000;
			step_r <= 5'h00;
		end
		else
		begin
			unique case (dst_r)
				tach_pkg::DIV_IDLE:
				begin
					if (edge_p && !cfg_r.measure_method_select
						&& since_end > 20'(`SAMPLE_MS))
					begin
						num_r  <= {12'h000, prescale_r} * 32'(`KILO);
						rem_r  <= 32'h00000000;
						quo_r  <= 32'h00000000;
						step_r <= 5'h00;
						dst_r  <= tach_pkg::DIV_RUN;
					end
				end
				tach_pkg::DIV_RUN:
				begin
					num_r <= num_r << 1;
					if (rem_sh >= {13'h0000, period_r})
					begin
						rem_r <= 32'(rem_sh - {13'h0000, period_r});
						quo_r <= {quo_r[30:0], 1'b1};
					end
					else
					begin
						rem_r <= rem_sh[31:0];
						quo_r <= {quo_r[30:0], 1'b0};
					end
					step_r <= step_r + 5'h01;
					if (step_r == 5'h1F)
						dst_r <= tach_pkg::DIV_DONE;
				end
				tach_pkg::DIV_DONE:
					dst_r <= tach_pkg::DIV_IDLE;
			endcase
		end
	end

	always_comb
	begin
		samp = '0;
		if (cfg_r.measure_method_select)
		begin
			samp.vld = edge_p && period_r != 20'hFFFFF;
			samp.val = {12'h000, since_end};
		end
		else if (dst_r == tach_pkg::DIV_DONE)
		begin
			samp.vld = 1'b1;
			samp.val = quo_r;
		end
		else if (tick && win_r == 8'(`SAMPLE_MS - 1) && !low_rate && !starting)
		begin
			samp.vld = 1'b1;
			samp.val = 32'(pcnt_r) * 32'(`PER_SEC) * {12'h000, prescale_r};
		end
	end

	tach_average #(
		.DEPTH (16),
		.LW    (3)
	) u_avg (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.restart (cfg_wr),
		.moving  (cfg_r.moving_average),
		.lvl     (cfg_r.avg_level > 3'h4 ? 3'h4 : cfg_r.avg_level),
		.in_s    (samp),
		.out_s   (avg_s)
	);

	////////////////////////////////////////////////////////////////
	// value frozen in hold
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			value_r <= 32'h00000000;
			raw_r   <= 32'h00000000;
		end
		else if (!hold_a)
		begin
			if (!cfg_r.measure_method_select && azero_hit)
			begin
				value_r <= 32'h00000000;
				raw_r   <= 32'h00000000;
			end
			else
			begin
				if (avg_s.vld)
					value_r <= avg_s.val;
				if (samp.vld)
					raw_r <= samp.val;
			end
		end
	end

	// period mode compares the raw sample
	assign cmp_v   = cfg_r.measure_method_select ? raw_r : value_r;
	assign cmp_upd = !hold_a && !starting;

	// hysteresis flags: over sv1, over sv2, under sv1, under sv2
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || starting)
			flag_r <= 4'h0;
		else if (cmp_upd)
		begin
			flag_r[0] <= sv_ok(sv1_r, prescale_r) & over_f(flag_r[0], cmp_v, sv1_r, hyst_r);
			flag_r[1] <= sv_ok(sv2_r, prescale_r) & over_f(flag_r[1], cmp_v, sv2_r, hyst_r);
			flag_r[2] <= under_f(flag_r[2], cmp_v, sv1_r, hyst_r);
			flag_r[3] <= under_f(flag_r[3], cmp_v, sv2_r, hyst_r);
		end
	end

	always_comb
	begin
		want = 2'b00;
		unique case (tach_pkg::cmp_mode_t'(cfg_r.cmp_mode))
			tach_pkg::BAND_OUTSIDE_MODE: want[0] = flag_r[1] | flag_r[2];
			tach_pkg::BAND_INSIDE_MODE:  want[0] = ~flag_r[1] & ~flag_r[2];
			tach_pkg::OVER_MAX_MODE:     want[0] = flag_r[0];
			tach_pkg::UNDER_MIN_MODE:    want[0] = flag_r[2];
			tach_pkg::DOUBLE_OVER_MODE:  want    = {flag_r[1], flag_r[0]};
			tach_pkg::DOUBLE_UNDER_MODE: want    = {flag_r[3], flag_r[2]};
			default:                     want    = 2'b00;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		for (int k = 0; k < 2; k++)
		begin
			if (sys_rst || starting)
			begin
				drive_r[k]    <= 1'b0;
				hold_cnt_r[k] <= 16'h0000;
			end
			else if (cmp_upd)
			begin
				if (want[k])
				begin
					drive_r[k]    <= 1'b1;
					hold_cnt_r[k] <= 16'h0000;
				end
				else if (drive_r[k] && hold_cnt_r[k] >= offdly_r)
					drive_r[k] <= 1'b0;
				else if (drive_r[k] && tick)
					hold_cnt_r[k] <= hold_cnt_r[k] + 16'h0001;
			end
		end
	end
	assign first_control_output  = drive_r[0];
	assign second_control_output = drive_r[1];
	assign hold_led              = hold_a;
	assign decimal_point_place   = cfg_r.decimal_point_place;

	// count off-to-on edges; thousands kept apart
	always_ff @(posedge clk_sys)
	begin
		out_p_r <= sys_rst ? 2'b00 : drive_r;
		for (int k = 0; k < 2; k++)
		begin
			if (sys_rst)
			begin
				on_lo_r[k] <= 10'h000;
				on_hi_r[k] <= 32'h00000000;
			end
			else if (drive_r[k] && !out_p_r[k])
			begin
				if (on_lo_r[k] == 10'(`KILO - 1))
				begin
					on_lo_r[k] <= 10'h000;
					on_hi_r[k] <= on_hi_r[k] + 32'h00000001;
				end
				else
					on_lo_r[k] <= on_lo_r[k] + 10'h001;
			end
		end
	end

	// peak and bottom; peak restored from store at reset
	always_ff @(posedge clk_sys)
	begin
		peak_save <= 1'b0;
		if (sys_rst)
		begin
			peak_r   <= peak_nv_i;
			bottom_r <= 32'hFFFFFFFF;
		end
		else if (cfg_wr)
		begin
			peak_r    <= 32'h00000000;
			bottom_r  <= 32'hFFFFFFFF;
			peak_save <= 1'b1;
		end
		else if (cfg_r.peak_bottom_capture_enable && avg_s.vld && !hold_a)
		begin
			if (avg_s.val > peak_r)
			begin
				peak_r    <= avg_s.val;
				peak_save <= 1'b1;
			end
			if (avg_s.val < bottom_r)
				bottom_r <= avg_s.val;
		end
	end
	assign peak_nv_o = peak_r;

	////////////////////////////////////////////////////////////////
	// Wishbone slave: one wait state, ack drops after one cycle
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign cfg_wr = wb_req & wb_we_i
		& (wb_adr_i == `ADR_CTRL || wb_adr_i == `ADR_PRESCALE);

	// Writable registers
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			cfg_r      <= tach_pkg::cfg_t'(`CTRL_RST);
			prescale_r <= `PRESCALE_RST;
			sv1_r      <= 32'h00000000;
			sv2_r      <= 32'h00000000;
			hyst_r     <= 32'h00000000;
			azero_r    <= `AZERO_RST;
			startup_r  <= `STARTUP_RST;
			offdly_r   <= `OFFDLY_RST;
			svlim_r    <= `SVLIMIT_RST;
		end
		else if (wb_req && wb_we_i)
		begin
			unique case (wb_adr_i)
				`ADR_CTRL:     cfg_r      <= tach_pkg::cfg_t'(14'(lanes(
					{18'h00000, cfg_r}, wb_dat_i, wb_sel_i)));
				`ADR_PRESCALE: prescale_r <= 20'(lanes({12'h000, prescale_r},
					wb_dat_i, wb_sel_i));
				`ADR_SV1:      sv1_r <= clamp(lanes(sv1_r, wb_dat_i, wb_sel_i), svlim_r);
				`ADR_SV2:      sv2_r <= clamp(lanes(sv2_r, wb_dat_i, wb_sel_i), svlim_r);
				`ADR_HYST:     hyst_r <= lanes(hyst_r, wb_dat_i, wb_sel_i);
				`ADR_AZERO:    azero_r <= 16'(lanes({16'h0000, azero_r},
					wb_dat_i, wb_sel_i));
				`ADR_STARTUP:  startup_r <= 16'(lanes({16'h0000, startup_r},
					wb_dat_i, wb_sel_i));
				`ADR_OFFDLY:   offdly_r <= 16'(lanes({16'h0000, offdly_r},
					wb_dat_i, wb_sel_i));
				`ADR_SVLIMIT:  svlim_r <= lanes(svlim_r, wb_dat_i, wb_sel_i);
				default:       cfg_r <= cfg_r;
			endcase
		end
	end

	// Read data and ack; unmapped addresses read zero
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= wb_req;
			if (wb_req)
			begin
				unique case (wb_adr_i)
					`ADR_CTRL:     wb_dat_o <= {18'h00000, cfg_r};
					`ADR_PRESCALE: wb_dat_o <= {12'h000, prescale_r};
					`ADR_SV1:      wb_dat_o <= sv1_r;
					`ADR_SV2:      wb_dat_o <= sv2_r;
					`ADR_HYST:     wb_dat_o <= hyst_r;
					`ADR_AZERO:    wb_dat_o <= {16'h0000, azero_r};
					`ADR_STARTUP:  wb_dat_o <= {16'h0000, startup_r};
					`ADR_OFFDLY:   wb_dat_o <= {16'h0000, offdly_r};
					`ADR_SVLIMIT:  wb_dat_o <= svlim_r;
					`ADR_VALUE:    wb_dat_o <= value_r;
					`ADR_PEAK:     wb_dat_o <= peak_r;
					`ADR_BOTTOM:   wb_dat_o <= bottom_r;
					`ADR_ONMON1:   wb_dat_o <= on_hi_r[0];
					`ADR_ONMON2:   wb_dat_o <= on_hi_r[1];
					`ADR_STATUS:   wb_dat_o <= {27'h0000000, azero_hit, starting,
						hold_a, drive_r};
					default:       wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end
endmodule

// ### verification/pulse_src.sv
`timescale 1ns/100ps
module pulse_src (
	input wire logic        clk_sys,
	input wire logic        en,
	input wire logic [15:0] half,
	output logic            count_in = 1'b0
);
	logic [15:0] cnt_r = 16'h0;

	// Square wave sensor; an idle contact rests low so no stray edge appears
	always @(posedge clk_sys)
	begin
		if (!en)
		begin
			cnt_r    <= 16'h0;
			count_in <= 1'b0;
		end
		else if (cnt_r >= half - 16'h1)
		begin
			cnt_r    <= 16'h0;
			count_in <= !count_in;
		end
		else
			cnt_r <= cnt_r + 16'h1;
	end
endmodule

// ### verification/tach_checker_asserts.sv
`timescale 1ns/100ps
module tach_checker (
	input wire logic        clk_sys,
	input wire logic        sys_rst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        hold_in,
	input wire logic        hold_led,
	input wire logic        first_control_output,
	input wire logic        second_control_output,
	input wire logic [2:0]  decimal_point_place
);
	logic [2:0] mode_r;
	logic [2:0] dp_r;
	logic       npn_r;
	logic [2:0] age_r;
	logic       ctrl_wr;

	// Shadow of the control word, aged so outputs get time to settle
	assign ctrl_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h00;
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			mode_r <= 3'h0;
			dp_r   <= 3'h0;
			npn_r  <= 1'b0;
			age_r  <= 3'h0;
		end
		else if (ctrl_wr)
		begin
			mode_r <= wb_sel_i[0] ? wb_dat_i[5:3] : mode_r;
			npn_r  <= wb_sel_i[0] ? wb_dat_i[2] : npn_r;
			dp_r   <= wb_sel_i[1] ? wb_dat_i[12:10] : dp_r;
			age_r  <= 3'h0;
		end
		else if (age_r != 3'h7)
			age_r <= age_r + 3'h1;
	end

	////////////////////////////////////////
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	// A new request taken by the slave
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_hole_read;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == 8'h3C;
	endsequence

	a_ack_after_req: assert property (s_req |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_unasked: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	a_hole_zero: assert property (s_hole_read |=> wb_ack_o && wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_second_control_output_quiet: assert property (age_r == 3'h7 && mode_r < 3'h4 |-> !second_control_output)
		else $error("second output on in single mode");
	a_dp_joint: assert property (age_r >= 3'h2 |-> decimal_point_place == dp_r)
		else $error("decimal place differs from control");
	a_hold_lamp: assert property (age_r == 3'h7 |-> hold_led == ($past(hold_in, 2) ^ npn_r))
		else $error("hold lamp wrong");
	a_hold_freeze: assert property (hold_led [*2] |-> $stable(first_control_output)
		&& $stable(second_control_output))
		else $error("outputs moved during hold");
endmodule

bind tachometer_measure_compare tach_checker u_chk (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .hold_in(hold_in), .hold_led(hold_led),
	.first_control_output(first_control_output),
	.second_control_output(second_control_output),
	.decimal_point_place(decimal_point_place)
);

// ### verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	logic        clk_sys, sys_rst, req, we, hold_in, en, o1, o2, ack, cin, led;
	logic [7:0]  adr;
	logic [31:0] dat, rdat, q, s, p;
	logic [15:0] half;
	int          err_total, compares, i;
	logic [7:0]  ra[7] = '{8'h00, 8'h04, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h3C};
	logic [31:0] rv[7] = '{32'h0, 32'h3E8, 32'h3E8, 32'h0, 32'h0, 32'hF423F, 32'h0};
	logic [31:0] sva[6] = '{32'h1388, 32'h1388, 32'h1388, 32'h4E20, 32'h1388, 32'h4E20};
	logic [31:0] svb[6] = '{32'h4E20, 32'h4E20, 32'h0, 32'h0, 32'h4E20, 32'h4E20};
	logic [1:0]  oxp[6] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h3};

	// One millisecond is ten clocks so the 200 ms window is 2000 cycles
	tachometer_measure_compare #(.MS_CYCLES(10)) u_dut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(req), .wb_stb_i(req),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .count_in(cin), .hold_in(hold_in), .peak_nv_i(32'h0),
		.peak_nv_o(), .peak_save(), .first_control_output(o1),
		.second_control_output(o2), .hold_led(led), .decimal_point_place());
	pulse_src u_src (.clk_sys(clk_sys), .en(en), .half(half), .count_in(cin));

	////////////////////////////////////////
	function automatic logic [31:0] rnd();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t got %h want %h", $time, seen, exp);
		end
	endtask
	// Classic cycle: hold the request until ack is sampled, then drop it
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		req <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		q = rdat;
		req <= 1'b0;
		if (n >= 50)
			chk(32'h1, 32'h0);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task automatic pause(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic report_and_stop();
		if (err_total == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	////////////////////////////////////////
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Watchdog sized well above the planned 84k cycles
	initial
	begin
		pause(110000);
		err_total++;
		report_and_stop();
	end
	initial
	begin
		{sys_rst, req, we, adr, dat, hold_in, en} = {1'b1, 10'h000, 32'h00000000, 2'h0};
		half = 16'h1F4;
		s = 32'h0c4fd52c;
		err_total = 0;
		compares = 0;
		pause(20);
		sys_rst <= 1'b0;
		for (i = 0; i < 7; i++)
			rdc(ra[i], rv[i]);
		xfer(1'b1, 8'h08, 32'h100000 | rnd());
		rdc(8'h08, 32'hF423F);
		xfer(1'b1, 8'h20, 32'h7530);
		p = rnd() % 32'h7530;
		xfer(1'b1, 8'h0C, p);
		rdc(8'h0C, p);
		xfer(1'b1, 8'h0C, 32'h9C40);
		rdc(8'h0C, 32'h7530);
		xfer(1'b1, 8'h20, 32'hF423F);
		xfer(1'b1, 8'h30, rnd());
		rdc(8'h30, 32'h0);
		// Random prescale at 10 Hz with a four-deep moving average
		en <= 1'b1;
		p = rnd() % 32'h7D0 + 32'h1;
		xfer(1'b1, 8'h00, 32'h150);
		xfer(1'b1, 8'h04, p);
		xfer(1'b1, 8'h08, p * 10 - 1);
		pause(11000);
		rdc(8'h24, p * 10);
		chk({31'h0, o1}, 32'h1);
		xfer(1'b1, 8'h10, 32'h3E8);
		xfer(1'b1, 8'h08, p * 10 + 500);
		pause(2100);
		chk({31'h0, o1}, 32'h1);
		xfer(1'b1, 8'h08, p * 10 + 1001);
		pause(2100);
		chk({31'h0, o1}, 32'h0);
		// Set value at the gate never turns on, one below does
		xfer(1'b1, 8'h10, 32'h0);
		xfer(1'b1, 8'h04, 32'h1869F);
		xfer(1'b1, 8'h08, 32'hDBBA0);
		// Prescale write refills the four-deep window, so wait five gates
		pause(10000);
		rdc(8'h24, 32'hF4236);
		chk({31'h0, o1}, 32'h0);
		xfer(1'b1, 8'h08, 32'hDBB9F);
		pause(2100);
		chk({31'h0, o1}, 32'h1);
		xfer(1'b1, 8'h04, 32'h3E8);
		for (i = 0; i < 6; i++)
		begin
			xfer(1'b1, 8'h00, 32'(i) << 3);
			xfer(1'b1, 8'h08, sva[i]);
			xfer(1'b1, 8'h0C, svb[i]);
			pause(4500);
			chk({30'h0, o2, o1}, {30'h0, oxp[i]});
		end
		// Hold keeps the old value while the rate doubles
		hold_in <= 1'b1;
		half <= 16'hFA;
		pause(3000);
		rdc(8'h24, 32'h2710);
		hold_in <= 1'b0;
		half <= 16'h1F4;
		xfer(1'b1, 8'h00, 32'h10);
		xfer(1'b1, 8'h08, 32'h1388);
		xfer(1'b1, 8'h14, 32'h96);
		xfer(1'b1, 8'h1C, 32'h32);
		pause(5000);
		en <= 1'b0;
		i = 0;
		do
		begin
			xfer(1'b0, 8'h24, 32'h0);
			i++;
		end
		while (q !== 32'h0 && i < 800);
		chk(q, 32'h0);
		chk({31'h0, o1}, 32'h1);
		pause(600);
		chk({31'h0, o1}, 32'h0);
		// Below 5 Hz: 300 ms pulses computed per pulse
		xfer(1'b1, 8'h14, 32'h3E8);
		half <= 16'h5DC;
		en <= 1'b1;
		pause(12000);
		rdc(8'h24, 32'hD05);
		xfer(1'b1, 8'h00, 32'h3);
		half <= 16'h1F4;
		pause(5000);
		rdc(8'h24, 32'h64);
		// Capture on with a steady 100 ms period: peak and bottom agree
		xfer(1'b1, 8'h00, 32'h2003);
		pause(3000);
		rdc(8'h28, 32'h64);
		rdc(8'h2C, 32'h64);
		report_and_stop();
	end
endmodule
